// [hw/tcss_pkg.sv]
/*
  Package for the trace count and State1 sequencer block: register map,
  field positions, reset values, sequencer state codes and carrier types.
  Assumes an AXI4-Lite register bus with 32-bit data.
*/
package tcss_pkg;
  // Word indices scaled by four to byte addresses; printed offsets 0x26/0x27 are not multiples of four
  localparam logic [7:0]  IDX_TRACE_COUNT = 8'h26;
  localparam logic [7:0]  IDX_STATE_WIN   = 8'h27;
  localparam logic [7:0]  IDX_CONTROL     = 8'h20;
  localparam logic [7:0]  IDX_STATUS      = 8'h21;
  localparam logic [11:0] ADDR_TRACE_COUNT = {2'b00, IDX_TRACE_COUNT, 2'b00};
  localparam logic [11:0] ADDR_STATE_WIN   = {2'b00, IDX_STATE_WIN, 2'b00};
  localparam logic [11:0] ADDR_CONTROL     = {2'b00, IDX_CONTROL, 2'b00};
  localparam logic [11:0] ADDR_STATUS      = {2'b00, IDX_STATUS, 2'b00};

  // Control register fields and status full-flag bit
  localparam int CTL_ARM_BIT    = 7;
  localparam int CTL_ALIGN_BIT  = 2;
  localparam int CTL_WIN_LSB    = 0;
  localparam int FULL_BIT       = 7;

  localparam logic [1:0] WIN_STATE1 = 2'h0;
  localparam logic [1:0] WIN_STATE2 = 2'h1;
  localparam logic [1:0] WIN_STATE3 = 2'h2;
  localparam logic [1:0] WIN_MATCH  = 2'h3;

  localparam logic [2:0] SEL_RESET  = 3'h0;
  localparam logic [5:0] COUNT_ZERO = 6'h00;
  localparam logic [5:0] COUNT_MAX  = 6'h3f;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sequencer state codes as reported in the status register
  localparam logic [2:0] SSF_IDLE   = 3'h0;
  localparam logic [2:0] SSF_STATE1 = 3'h1;
  localparam logic [2:0] SSF_STATE2 = 3'h2;
  localparam logic [2:0] SSF_STATE3 = 3'h3;
  localparam logic [2:0] SSF_FINAL  = 3'h4;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b0_0001,
    ST_ONE    = 5'b0_0010,
    ST_TWO    = 5'b0_0100,
    ST_THREE  = 5'b0_1000,
    ST_FINAL  = 5'b1_0000
  } tcss_state_t;

  typedef struct packed {
    logic [2:0] match;   // Comparator match channels 0..2
    logic       tagHit;  // Tag hit accompanying a match
  } tcss_match_t;

  typedef struct packed {
    logic       fullFlag;
    logic [5:0] lineCount;
  } tcss_count_t;
endpackage : tcss_pkg

// [hw/tcss_line_counter.sv]
/*
  Trace line counter with full flag.
  Assumes the power-on reset is the only reset that reaches it.
*/
`timescale 1ns/1ns
module tcss_line_counter (
  input  wire logic                 clk,
  input  wire logic                 porReset,
  input  wire logic                 armWrite,
  input  wire logic                 lineStore,
  output tcss_pkg::tcss_count_t     countState
);
  import tcss_pkg::*;

  logic [5:0] lineCount;
  logic       fullFlag;
  wire        wrap = lineStore && (lineCount == COUNT_MAX);

  always_ff @(posedge clk or posedge porReset) begin
    if (porReset) begin
      lineCount <= COUNT_ZERO;
      fullFlag  <= 1'b0;
    end else if (armWrite) begin
      lineCount <= COUNT_ZERO;
      fullFlag  <= 1'b0;
    end else if (lineStore) begin
      lineCount <= lineCount + 6'h01;
      if (wrap) begin
        fullFlag <= 1'b1;
      end
    end
  end

  assign countState = '{fullFlag: fullFlag, lineCount: lineCount};

  property p_wrap_sets_full;
    @(posedge clk) disable iff (porReset)
    (wrap && !armWrite) |=> (fullFlag && lineCount == COUNT_ZERO);
  endproperty
  a_wrap_sets_full: assert property (p_wrap_sets_full)
    else $error("Wrap did not set full flag");

  property p_count_steady;
    @(posedge clk) disable iff (porReset)
    (!lineStore && !armWrite) |=> $stable(lineCount) && $stable(fullFlag);
  endproperty
  a_count_steady: assert property (p_count_steady)
    else $error("Count changed without a store or arm");
endmodule : tcss_line_counter

// [hw/tcss_core.sv]
/*
  Trace count register and State1 sequencer with AXI4-Lite slave.
  Assumes matches and line stores come from logic on clk; porReset is
  the power-on reset, reset is any system reset.
*/
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
// Overview of operation
// - Full flag sets once 64 or more lines stored since last arm.
// - With full flag set all 64 lines count as valid.
// - Writing one to arm clears full flag and line count.
// - Only power-on reset clears flag and count; other resets keep them.
// - Six-bit line count in bits 5..0 gives valid line total.
// - Count wrap to zero sets full flag; end-trigger mode keeps counting.
// - Trace reads never decrement count; only store, arm, power-on change it.
// - Trace count register readable anytime; writes ignored.
// - Begin alignment: reaching 64 lines clears arm, ends session.
// - Full flag with nonzero count means newest lines overwrote oldest.
// - Full flag also visible at status register bit 7.
// - Shared address shows State1, State2, State3 or match flags by select.
// - State1 register readable at select 00, writable only then and disarmed.
// - State1 register holds 3-bit code in bits 2..0, upper zero, resets zero.
// - Codes 000-011 route any/ch1/ch2/ch1 to final/State3/State2/State2.
// - Codes 100-111 route channel zero, one, two as tabulated.
// - Simultaneous matches: lowest-numbered channel wins.
// - A match leading to final state beats other matches.
// - Leaving states one to three only on match, tag hit or disarm (back to idle).
module tcss_core (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 porReset,
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire tcss_pkg::tcss_match_t matchIn,
  input  wire logic                 lineStore,
  input  wire logic [7:0]           state2Select,
  input  wire logic [7:0]           state3Select,
  input  wire logic [7:0]           matchFlags,
  input  wire logic [2:0]           nextFromState2,
  input  wire logic [2:0]           nextFromState3,
  output logic                      armed,
  output logic                      traceFull,
  output logic [6:0]                validLines,
  output logic [2:0]                seqStateCode
);
  import tcss_pkg::*;

  // Control: arm, alignment (1 = begin trigger), window select
  logic        arm;
  logic        alignBegin;
  logic [1:0]  windowSelect;
  logic [2:0]  state1Code;
  tcss_state_t state;
  tcss_state_t next_state;
  tcss_count_t countState;

  // Write channel capture
  logic        awHeld;
  logic        wHeld;
  logic [11:0] awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  wire awTake   = s_axi_awvalid && s_axi_awready;
  wire wTake    = s_axi_wvalid && s_axi_wready;
  wire haveAw   = awHeld || awTake;
  wire haveW    = wHeld || wTake;
  wire doWrite  = haveAw && haveW && !s_axi_bvalid;
  wire [11:0] wrAddr = awHeld ? awAddr : s_axi_awaddr;
  wire [31:0] wrData = wHeld ? wData : s_axi_wdata;
  wire [3:0]  wrStrb = wHeld ? wStrb : s_axi_wstrb;
  wire        lane0  = wrStrb[0];

  wire wrControl  = doWrite && (wrAddr == ADDR_CONTROL);
  wire wrWindow   = doWrite && (wrAddr == ADDR_STATE_WIN);
  wire wrCount    = doWrite && (wrAddr == ADDR_TRACE_COUNT);
  wire wrStatus   = doWrite && (wrAddr == ADDR_STATUS);
  wire wrMapped   = wrControl || wrWindow || wrCount || wrStatus;
  wire armWrite   = wrControl && lane0 && wrData[CTL_ARM_BIT];
  wire state1Wr   = wrWindow && lane0 && (windowSelect == WIN_STATE1)
                    && !arm;

  // Begin alignment ends the session when the 64th line lands
  wire lastLine   = lineStore && arm && (countState.lineCount == COUNT_MAX);
  wire autoDisarm = lastLine && alignBegin && !countState.fullFlag;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= 12'h000;
      wData  <= 32'h0000_0000;
      wStrb  <= 4'h0;
    end else begin
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
      end else begin
        if (awTake) begin
          awHeld <= 1'b1;
          awAddr <= s_axi_awaddr;
        end
        if (wTake) begin
          wHeld <= 1'b1;
          wData <= s_axi_wdata;
          wStrb <= s_axi_wstrb;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      arm          <= 1'b0;
      alignBegin   <= 1'b0;
      windowSelect <= WIN_STATE1;
    end else begin
      if (wrControl && lane0) begin
        arm          <= wrData[CTL_ARM_BIT];
        alignBegin   <= wrData[CTL_ALIGN_BIT];
        windowSelect <= wrData[CTL_WIN_LSB +: 2];
      end else if (autoDisarm) begin
        arm <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state1Code <= SEL_RESET;
    end else if (state1Wr) begin
      state1Code <= wrData[2:0];
    end
  end

  tcss_line_counter u_counter (
    .clk        (clk),
    .porReset   (porReset),
    .armWrite   (armWrite),
    .lineStore  (lineStore && arm),
    .countState (countState)
  );

  // Next state from State1; lowest channel first, final-state routes first
  wire [2:0] m   = matchIn.match;
  wire       hit = |m || matchIn.tagHit;
  tcss_state_t fromOne;
  always_comb begin
    fromOne = ST_ONE;
    case (state1Code)
      3'h0: if (hit) fromOne = ST_FINAL;
      3'h1: if (m[1]) fromOne = ST_THREE;
      3'h2: if (m[2]) fromOne = ST_TWO;
      3'h3: if (m[1]) fromOne = ST_TWO;
      3'h4: begin
        if (m[0]) fromOne = ST_TWO;
        else if (m[1]) fromOne = ST_THREE;
      end
      3'h5: begin
        if (m[0]) fromOne = ST_FINAL;
        else if (m[1]) fromOne = ST_THREE;
      end
      3'h6: begin
        if (m[0]) fromOne = ST_TWO;
        else if (m[2]) fromOne = ST_THREE;
      end
      default: if (m[0] || m[1]) fromOne = ST_TWO;
    endcase
  end

  function automatic tcss_state_t code_to_state(input logic [2:0] code);
    case (code)
      SSF_STATE1: code_to_state = ST_ONE;
      SSF_STATE2: code_to_state = ST_TWO;
      SSF_STATE3: code_to_state = ST_THREE;
      SSF_FINAL:  code_to_state = ST_FINAL;
      default:    code_to_state = ST_IDLE;
    endcase
  endfunction : code_to_state

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  if (arm) next_state = ST_ONE;
      ST_ONE:   next_state = fromOne;
      ST_TWO:   if (hit && nextFromState2 != SSF_IDLE)
                  next_state = code_to_state(nextFromState2);
      ST_THREE: if (hit && nextFromState3 != SSF_IDLE)
                  next_state = code_to_state(nextFromState3);
      ST_FINAL: next_state = ST_FINAL;
      default:  next_state = ST_IDLE;
    endcase
    if (!arm) next_state = ST_IDLE;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign seqStateCode = (state == ST_ONE)   ? SSF_STATE1 :
                        (state == ST_TWO)   ? SSF_STATE2 :
                        (state == ST_THREE) ? SSF_STATE3 :
                        (state == ST_FINAL) ? SSF_FINAL  : SSF_IDLE;
  assign armed      = arm;
  assign traceFull  = countState.fullFlag;
  assign validLines = countState.fullFlag ? 7'h40
                      : {1'b0, countState.lineCount};

  // Read path
  wire [7:0] countByte  = {countState.fullFlag, 1'b0, countState.lineCount};
  wire [7:0] statusByte = {countState.fullFlag, 4'h0, seqStateCode};
  wire [7:0] ctlByte    = {arm, 4'h0, alignBegin, windowSelect};
  wire [7:0] state1Byte = {5'h00, state1Code};
  wire [7:0] windowByte = (windowSelect == WIN_STATE1) ? state1Byte :
                          (windowSelect == WIN_STATE2) ? state2Select :
                          (windowSelect == WIN_STATE3) ? state3Select :
                          matchFlags;
  wire       rdCount    = (s_axi_araddr == ADDR_TRACE_COUNT);
  wire       rdWindow   = (s_axi_araddr == ADDR_STATE_WIN);
  wire       rdControl  = (s_axi_araddr == ADDR_CONTROL);
  wire       rdStatus   = (s_axi_araddr == ADDR_STATUS);
  wire       rdMapped   = rdCount || rdWindow || rdControl || rdStatus;
  wire [7:0] rdByte;
  assign rdByte = rdCount   ? countByte :
                  rdWindow  ? windowByte :
                  rdControl ? ctlByte :
                  rdStatus  ? statusByte : 8'h00;

  assign s_axi_arready = !s_axi_rvalid;
  wire arTake = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (arTake) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rdByte};
      s_axi_rresp  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Assertions
  property p_arm_clears;
    @(posedge clk) disable iff (reset || porReset)
    armWrite |=> (countState.lineCount == COUNT_ZERO) && !countState.fullFlag;
  endproperty
  a_arm_clears: assert property (p_arm_clears)
    else $error("Arm write left count or flag");

  property p_begin_disarm;
    @(posedge clk) disable iff (reset || porReset)
    (autoDisarm && !wrControl) |=> !arm && countState.fullFlag;
  endproperty
  a_begin_disarm: assert property (p_begin_disarm)
    else $error("Begin alignment did not end session");

  property p_state1_locked;
    @(posedge clk) disable iff (reset)
    (arm && !(wrControl && lane0)) |=> $stable(state1Code);
  endproperty
  a_state1_locked: assert property (p_state1_locked)
    else $error("State1 code changed while armed");

  property p_full_lines;
    @(posedge clk) disable iff (reset || porReset)
    countState.fullFlag |-> validLines == 7'h40;
  endproperty
  a_full_lines: assert property (p_full_lines)
    else $error("Full flag without 64 valid lines");

  property p_status_mirror;
    @(posedge clk) disable iff (reset || porReset)
    (arTake && rdStatus) |=> s_axi_rdata[FULL_BIT] == $past(countState.fullFlag);
  endproperty
  a_status_mirror: assert property (p_status_mirror)
    else $error("Status full bit differs");

  property p_final_priority;
    @(posedge clk) disable iff (reset)
    (state == ST_ONE && arm && state1Code == 3'h5 && m[0]) |=> state == ST_FINAL;
  endproperty
  a_final_priority: assert property (p_final_priority)
    else $error("Channel zero did not reach final state");

  property p_low_channel;
    @(posedge clk) disable iff (reset)
    (state == ST_ONE && arm && state1Code == 3'h4 && m[0] && m[1]) |=> state == ST_TWO;
  endproperty
  a_low_channel: assert property (p_low_channel)
    else $error("Lower channel lost priority");

  property p_no_hit_stay;
    @(posedge clk) disable iff (reset)
    (state == ST_ONE && arm && !hit) |=> state == ST_ONE || !arm;
  endproperty
  a_no_hit_stay: assert property (p_no_hit_stay)
    else $error("State1 left without a match");

  property p_rd_answer;
    @(posedge clk) disable iff (reset)
    arTake |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("Read not answered next cycle");
endmodule : tcss_core

// [bench/tcss_far_model.sv]
/*
  Far-side model: CPU bus activity that feeds matches and line stores.
  Assumes its tasks are called by the bench and run on clk.
*/
`timescale 1ns/1ns
module tcss_far_model (
  input  wire logic             clk,
  output tcss_pkg::tcss_match_t matchIn,
  output logic                  lineStore,
  output logic [7:0]            state2Select,
  output logic [7:0]            state3Select,
  output logic [7:0]            matchFlags,
  output logic [2:0]            nextFromState2,
  output logic [2:0]            nextFromState3
);
  import tcss_pkg::*;
  localparam logic [7:0] SEL2 = 8'h5a;
  localparam logic [7:0] SEL3 = 8'hc3;
  localparam logic [7:0] FLGS = 8'h05;

  initial begin
    matchIn        = '0;
    lineStore      = 1'b0;
    nextFromState2 = 3'h0;
    nextFromState3 = 3'h0;
  end
  assign state2Select   = SEL2;
  assign state3Select   = SEL3;
  assign matchFlags     = FLGS;

  // Later-state targets; zero keeps State2/State3 put
  task automatic route(input logic [2:0] two, input logic [2:0] three);
    @(posedge clk);
    nextFromState2 <= two;
    nextFromState3 <= three;
  endtask : route

  // Stores n lines, mostly back to back, stalling every fourth line
  task automatic store(input int n);
    for (int i = 0; i < n; i++) begin
      if (i % 4 == 3) begin
        @(posedge clk);
        lineStore <= 1'b0;
      end
      @(posedge clk);
      lineStore <= 1'b1;
    end
    @(posedge clk);
    lineStore <= 1'b0;
    // Let the last store settle before anyone samples outputs
    @(posedge clk);
  endtask : store

  // One-cycle match on enabled comparators only
  task automatic hit(input logic [2:0] m);
    @(posedge clk);
    matchIn <= {m, |m};
    @(posedge clk);
    matchIn <= '0;
  endtask : hit
endmodule : tcss_far_model

// [bench/tb_trace_count_and_state1_sequencer.sv]
/*
  Self-checking bench for the trace count and State1 sequencer core.
  Assumes the AXI4-Lite timing and register map of the core's package.
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) begin totalChecks++; if ((e) !== (g)) begin badCount++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_trace_count_and_state1_sequencer;
  import tcss_pkg::*;
  logic        clk, reset, porReset, lineStore, armed, traceFull;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  sel2, sel3, mflags;
  logic [7:0]  winVal [4];
  logic [2:0]  nx2, nx3, seqStateCode;
  logic [6:0]  validLines;
  logic [33:0] rdQ [$];
  logic [1:0]  bQ [$];
  tcss_match_t matchIn;
  int          badCount = 0, totalChecks = 0, cyc = 0, seed = 64;

  tcss_core uut (.clk(clk), .reset(reset), .porReset(porReset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .matchIn(matchIn),
    .lineStore(lineStore), .state2Select(sel2), .state3Select(sel3),
    .matchFlags(mflags), .nextFromState2(nx2), .nextFromState3(nx3),
    .armed(armed), .traceFull(traceFull), .validLines(validLines),
    .seqStateCode(seqStateCode));

  tcss_far_model far (.clk(clk), .matchIn(matchIn), .lineStore(lineStore),
    .state2Select(sel2), .state3Select(sel3), .matchFlags(mflags),
    .nextFromState2(nx2), .nextFromState3(nx3));

  assign winVal = '{8'h07, sel2, sel3, mflags};

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : printVerdict

  // Result monitor and hang guard
  always @(posedge clk) begin
    if (rvalid && rready) `CHK("read", rdQ.pop_front(), {rresp, rdata})
    if (bvalid && bready) `CHK("bresp", bQ.pop_front(), bresp)
    cyc++;
    if (cyc > 20000) begin
      badCount++;
      printVerdict();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    logic ad, wd;
    bQ.push_back(r);
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h0, d};
    wstrb   <= 4'($random(seed)) | 4'h1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    rdQ.push_back({r, 24'h0, d});
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
  endtask : rd

  // Target per channel {ch0,ch1,ch2}; 1 means no move
  function automatic logic [2:0] nextOf(input logic [2:0] c, input logic [2:0] m);
    logic [8:0] t;
    case (c)
      3'h0: t = 9'o444;
      3'h1: t = 9'o131;
      3'h2: t = 9'o112;
      3'h3: t = 9'o121;
      3'h4: t = 9'o231;
      3'h5: t = 9'o431;
      3'h6: t = 9'o213;
      default: t = 9'o221;
    endcase
    for (int k = 0; k < 3; k++)
      if (m[k] && t[8-3*k -: 3] == 3'h4) return 3'h4;
    for (int k = 0; k < 3; k++)
      if (m[k] && t[8-3*k -: 3] != 3'h1) return t[8-3*k -: 3];
    return 3'h1;
  endfunction : nextOf

  task automatic pulseReset(input logic por);
    @(posedge clk);
    reset    <= 1'b1;
    porReset <= por;
    repeat (3) @(posedge clk);
    reset    <= 1'b0;
    porReset <= 1'b0;
  endtask : pulseReset

  initial begin
    logic [2:0] code, m;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'h1;
    reset = 1'b1; porReset = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    porReset <= 1'b0;
    rd(ADDR_TRACE_COUNT, 8'h00, RESP_OKAY);
    rd(ADDR_STATE_WIN, 8'h00, RESP_OKAY);
    rd(12'h0FC, 8'h00, RESP_SLVERR);
    wr(12'h0F0, 8'h11, RESP_SLVERR);
    wr(ADDR_TRACE_COUNT, 8'hff, RESP_OKAY);
    rd(ADDR_TRACE_COUNT, 8'h00, RESP_OKAY);
    $display("test reset and map done");
    wr(ADDR_STATE_WIN, 8'hff, RESP_OKAY);
    rd(ADDR_STATE_WIN, 8'h07, RESP_OKAY);
    for (int w = 1; w < 4; w++) begin
      wr(ADDR_CONTROL, 8'(w), RESP_OKAY);
      wr(ADDR_STATE_WIN, 8'h02, RESP_OKAY);
      rd(ADDR_STATE_WIN, winVal[w], RESP_OKAY);
    end
    wr(ADDR_CONTROL, 8'h00, RESP_OKAY);
    rd(ADDR_STATE_WIN, 8'h07, RESP_OKAY);
    wr(ADDR_CONTROL, 8'h80, RESP_OKAY);
    wr(ADDR_STATE_WIN, 8'h03, RESP_OKAY);
    rd(ADDR_STATE_WIN, 8'h07, RESP_OKAY);
    $display("test state1 window done");
    wr(ADDR_CONTROL, 8'h80, RESP_OKAY);
    far.store(10);
    rd(ADDR_TRACE_COUNT, 8'h0a, RESP_OKAY);
    `CHK("validLines", 7'd10, validLines)
    far.store(54);
    rd(ADDR_TRACE_COUNT, 8'h80, RESP_OKAY);
    `CHK("traceFull", 1'b1, traceFull)
    rd(ADDR_STATUS, 8'h81, RESP_OKAY);
    far.store(3);
    rd(ADDR_TRACE_COUNT, 8'h83, RESP_OKAY);
    `CHK("validLines", 7'd64, validLines)
    pulseReset(1'b0);
    rd(ADDR_TRACE_COUNT, 8'h83, RESP_OKAY);
    wr(ADDR_CONTROL, 8'h80, RESP_OKAY);
    rd(ADDR_TRACE_COUNT, 8'h00, RESP_OKAY);
    far.store(2);
    pulseReset(1'b1);
    rd(ADDR_TRACE_COUNT, 8'h00, RESP_OKAY);
    `CHK("traceFull", 1'b0, traceFull)
    $display("test end-trigger count done");
    wr(ADDR_CONTROL, 8'h84, RESP_OKAY);
    far.store(64);
    `CHK("armed", 1'b0, armed)
    rd(ADDR_TRACE_COUNT, 8'h80, RESP_OKAY);
    far.store(2);
    rd(ADDR_TRACE_COUNT, 8'h80, RESP_OKAY);
    $display("test begin-trigger count done");
    for (int i = 0; i < 24; i++) begin
      code = (i < 8) ? 3'(i) : 3'($random(seed));
      m = (i < 8) ? 3'b111 : 3'($random(seed));
      wr(ADDR_CONTROL, 8'h00, RESP_OKAY);
      wr(ADDR_STATE_WIN, {5'h00, code}, RESP_OKAY);
      wr(ADDR_CONTROL, 8'h80, RESP_OKAY);
      rd(ADDR_STATUS, 8'h01, RESP_OKAY);
      far.hit(m);
      rd(ADDR_STATUS, {5'h00, nextOf(code, m)}, RESP_OKAY);
      `CHK("seqState", nextOf(code, m), seqStateCode)
    end
    far.route(3'h4, 3'h1);
    for (int j = 0; j < 2; j++) begin
      wr(ADDR_CONTROL, 8'h00, RESP_OKAY);
      wr(ADDR_STATE_WIN, j ? 8'h01 : 8'h03, RESP_OKAY);
      wr(ADDR_CONTROL, 8'h80, RESP_OKAY);
      far.hit(3'b010);
      rd(ADDR_STATUS, j ? 8'h03 : 8'h02, RESP_OKAY);
      far.hit(3'b001);
      rd(ADDR_STATUS, j ? 8'h01 : 8'h04, RESP_OKAY);
    end
    $display("test sequencer done");
    printVerdict();
  end
endmodule : tb_trace_count_and_state1_sequencer
